// ### ioproc_pkg.sv
package ioproc_pkg;
  // Clock rate and line rates
  localparam int unsigned CLK_HZ    = 200_000_000;
  localparam int unsigned OVS       = 16;  // Ticks per serial bit
  localparam int unsigned BAUD_110  = 110;
  localparam int unsigned BAUD_300  = 300;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_9600 = 9600;

  // Register byte offsets
  localparam logic [3:0] ADR_CTRL  = 4'h0;
  localparam logic [3:0] ADR_CMD   = 4'h4;
  localparam logic [3:0] ADR_START = 4'h8;
  localparam logic [3:0] ADR_STAT  = 4'hC;

  // Control register fields and reset value
  localparam int CF_BAUD   = 0;  // Three bits, 0 = 110 .. 4 = 9600
  localparam int CF_EXTCLK = 3;  // Cassette supplies the shift clock when recording
  localparam int CF_EOMCR  = 4;  // End of message sent as CR, else EOT
  localparam int CF_PAR    = 5;  // Printer on the parallel port
  localparam int CF_RXCAS  = 6;  // Receive from cassette, else host
  localparam int CF_DUPLEX = 7;  // Forward keyboard to host
  localparam logic [7:0] CTRL_RST = 8'h04;

  // Command and status bits
  localparam int CB_RECV  = 0;
  localparam int CB_LOCAL = 1;
  localparam int CB_XMIT  = 2;
  localparam int CB_PRINT = 3;
  localparam int SB_PERR  = 2;

  // Synchroniser bit positions and reset value (lines idle at mark)
  localparam int SY_HRX = 0;
  localparam int SY_CRX = 1;
  localparam int SY_CCK = 2;
  localparam int SY_REC = 3;
  localparam int SY_BSY = 4;
  localparam int SY_ONL = 5;
  localparam logic [5:0] SY_RST = 6'h03;

  // Screen geometry and character codes
  localparam logic [6:0] X_LAST  = 7'h49;
  localparam logic [4:0] Y_LAST  = 5'h1A;
  localparam logic [6:0] CH_CR   = 7'h0D;
  localparam logic [6:0] CH_LF   = 7'h0A;
  localparam logic [6:0] CH_EOT  = 7'h04;
  localparam logic [6:0] DISP_LO = 7'h20;
  localparam logic [6:0] DISP_HI = 7'h60;
  localparam logic [1:0] EOT_TAG = 2'h3;  // Memory bits 6:5 both set
  localparam logic [3:0] PRN_HOLD = 4'h4; // Cycles before busy is trusted

  typedef enum logic [1:0] {
    M_LOCAL = 2'b00, M_RECV = 2'b01, M_XMIT = 2'b10, M_PRINT = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    D_HOST = 2'b00, D_CAS = 2'b01, D_PSER = 2'b10, D_PPAR = 2'b11
  } dest_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_RD = 3'b001, S_RDW = 3'b010, S_OUT = 3'b011,
    S_OWT  = 3'b100, S_ADV = 3'b101, S_WR = 3'b110
  } st_t;
endpackage : ioproc_pkg

// ### link_if.sv
interface link_if;
  logic       tick;      // Oversampling tick
  logic       ext_tick;  // Cassette clock edge
  logic       tx_ext;    // Shift on cassette clock
  logic       tx_valid;
  logic       tx_ready;
  logic       tx_par;    // Append parity
  logic [6:0] tx_data;
  logic       txd;
  logic       rxd;
  logic       rx_chk;    // Check parity
  logic       rx_valid;
  logic [6:0] rx_data;
  logic       rx_perr;
  modport ctl (output tick, ext_tick, tx_ext, tx_valid, tx_par, tx_data, rxd,
               rx_chk, input tx_ready, txd, rx_valid, rx_data, rx_perr);
  modport lnk (input tick, ext_tick, tx_ext, tx_valid, tx_par, tx_data, rxd,
               rx_chk, output tx_ready, txd, rx_valid, rx_data, rx_perr);
endinterface : link_if

// ### baud_gen.sv
module baud_gen import ioproc_pkg::*; #(
  parameter int unsigned DIV0 = CLK_HZ / (BAUD_110 * OVS),
  parameter int unsigned DIV1 = CLK_HZ / (BAUD_300 * OVS),
  parameter int unsigned DIV2 = CLK_HZ / (BAUD_1200 * OVS),
  parameter int unsigned DIV3 = CLK_HZ / (BAUD_2400 * OVS),
  parameter int unsigned DIV4 = CLK_HZ / (BAUD_9600 * OVS)
) (
  input  wire logic       clk_i,  // System clock
  input  wire logic       rst_i,  // Synchronous reset
  input  wire logic       en_i,   // Run the divider
  input  wire logic [2:0] sel_i,  // Rate select
  output logic            tick_o  // One-cycle tick
);
  typedef struct packed {
    logic [16:0] cnt;
    logic        tick;
  } bstate_t;
  bstate_t     q, d;
  logic [16:0] lim;

  if (DIV4 < 2 || DIV0 > 131072) begin : g_bad_div
    $error("baud_gen: divisor out of range");
  end

  // Rate select; unused codes fall back to the fastest rate
  always_comb begin
    d = q;
    d.tick = 1'b0;
    unique case (sel_i)
      3'h0:    lim = 17'(DIV0 - 1);
      3'h1:    lim = 17'(DIV1 - 1);
      3'h2:    lim = 17'(DIV2 - 1);
      3'h3:    lim = 17'(DIV3 - 1);
      default: lim = 17'(DIV4 - 1);
    endcase
    // Held at zero while off so each enable starts a clean period
    if (!en_i) begin
      d.cnt = 17'h0;
    end else if (q.cnt == 17'h0) begin
      d.cnt = lim;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - 17'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;
endmodule : baud_gen

// ### serial_link.sv
module serial_link import ioproc_pkg::*; (
  input  wire logic clk_i,  // System clock
  input  wire logic rst_i,  // Synchronous reset
  link_if.lnk       lk      // Control side
);
  typedef struct packed {
    logic       tbusy;
    logic [3:0] tos;
    logic [3:0] tn;
    logic [9:0] tsh;
    logic       txd;
    logic       rbusy;
    logic [3:0] ros;
    logic [3:0] rn;
    logic [7:0] rsh;
    logic       rv;
    logic [6:0] rd;
    logic       rpe;
  } lstate_t;
  lstate_t q, d;
  logic    adv;

  always_comb begin
    d = q;
    d.rv = 1'b0;
    adv = lk.tx_ext ? lk.ext_tick : (lk.tick && q.tos == 4'hF);  // [R10]
    if (lk.tick) begin
      d.tos = q.tos + 4'h1;
    end
    // Frame: start, seven data bits LSB first, parity or mark, stop
    if (!q.tbusy && lk.tx_valid) begin
      d.tbusy = 1'b1;
      d.tn = 4'hA;
      d.tos = 4'h0;
      d.tsh = {1'b1, lk.tx_par ? ^lk.tx_data : 1'b1, lk.tx_data, 1'b0};  // [R2]
    end else if (q.tbusy && adv) begin
      d.tsh = {1'b1, q.tsh[9:1]};
      d.tn = q.tn - 4'h1;
      if (q.tn == 4'h1) begin
        d.tbusy = 1'b0;
      end
    end
    d.txd = d.tbusy ? d.tsh[0] : 1'b1;
    // Receiver samples mid-bit; stays busy to mid stop bit, unchecked, so a zero parity
    // bit is never mistaken for the next start bit
    if (!q.rbusy) begin
      if (!lk.rxd) begin
        d.rbusy = 1'b1;
        d.ros = 4'h0;
        d.rn = 4'h0;
      end
    end else if (lk.tick) begin
      d.ros = q.ros + 4'h1;
      if (q.ros == 4'h7) begin
        d.rn = q.rn + 4'h1;
        if (q.rn == 4'h0 && lk.rxd) begin
          d.rbusy = 1'b0;  // Glitch, not a start bit
        end else if (q.rn == 4'h9) begin
          d.rbusy = 1'b0;
          d.rv = 1'b1;
          d.rd = q.rsh[6:0];
          d.rpe = lk.rx_chk && (^q.rsh);  // [R15]
        end else begin
          d.rsh = {lk.rxd, q.rsh[7:1]};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.txd <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign lk.tx_ready = ~q.tbusy;
  assign lk.txd      = q.txd;
  assign lk.rx_valid = q.rv;
  assign lk.rx_data  = q.rd;
  assign lk.rx_perr  = q.rpe;
endmodule : serial_link

// ### terminal_io_mode_processor.sv
// Summary of operation
// [R1] Transmit fetches foreground characters only and shifts them out serially.
// [R2] Host-bound characters get a parity bit appended.
// [R3] Transmit with printer on-line follows every CR with an LF.
// [R4] First EOT read in transmit sends EOT or CR, then receive mode.
// [R5] That EOT on the bottom line triggers delete and roll-up.
// [R6] Host returns an LF after the end-of-message code.
// [R7] Print fetches foreground and background characters to printer or cassette.
// [R8] Print sends CR then LF after each line's last character.
// [R9] Recording cassette gets print output; otherwise the printer does.
// [R10] Cassette data shifts at baud rate or cassette's own clock.
// [R11] Parallel printer port presents seven bits at once.
// [R12] Next parallel character waits until printer busy drops.
// [R13] Print EOT sends CR, LF and moves cursor to next line start.
// [R14] Two EOTs in a row in print also enter receive mode.
// [R15] Receive from host or cassette; parity checked on host only.
// [R16] Received codes: command out, or one of 65 displayables to memory.
// [R17] Write at last position rolls up; next goes to bottom line start.
// [R18] In duplex, keyboard characters are forwarded to the host.
// [R19] Local mode inhibits all external communication.
// [R20] Shift rate selectable: 110, 300, 1200, 2400, 9600 baud.
// [R21] Keyboard locked in transmit and print; these start from receive or local.
// [R22] Exactly one of four modes; reset gives local mode.
// [R23] Host parity failure sets a sticky status flag.
module terminal_io_mode_processor import ioproc_pkg::*; #(
  parameter int unsigned DIV_110  = CLK_HZ / (BAUD_110 * OVS),   // Clocks per tick
  parameter int unsigned DIV_300  = CLK_HZ / (BAUD_300 * OVS),
  parameter int unsigned DIV_1200 = CLK_HZ / (BAUD_1200 * OVS),
  parameter int unsigned DIV_2400 = CLK_HZ / (BAUD_2400 * OVS),
  parameter int unsigned DIV_9600 = CLK_HZ / (BAUD_9600 * OVS)
) (
  input  wire logic        clk_i,        // 200 MHz clock
  input  wire logic        rst_i,        // Synchronous reset
  input  wire logic        wb_cyc_i,     // Wishbone cycle
  input  wire logic        wb_stb_i,     // Wishbone strobe
  input  wire logic        wb_we_i,      // Write enable
  input  wire logic [3:0]  wb_adr_i,     // Byte address
  input  wire logic [3:0]  wb_sel_i,     // Byte lanes
  input  wire logic [31:0] wb_dat_i,     // Write data
  output logic      [31:0] wb_dat_o,     // Read data
  output logic             wb_ack_o,     // Acknowledge
  output logic             mem_req_o,    // Display memory request
  output logic             mem_we_o,     // Memory write
  output logic      [6:0]  mem_x_o,      // Column
  output logic      [4:0]  mem_y_o,      // Line
  output logic      [7:0]  mem_wdata_o,  // Write word, bit 7 foreground
  input  wire logic [7:0]  mem_rdata_i,  // Read word
  input  wire logic        mem_ack_i,    // Memory done
  input  wire logic        host_rxd_i,   // Host serial in
  output logic             host_txd_o,   // Host serial out
  input  wire logic        cas_rxd_i,    // Cassette playback
  output logic             cas_txd_o,    // Cassette record data
  input  wire logic        cas_clk_i,    // Cassette shift clock
  input  wire logic        cas_rec_i,    // Cassette attached and recording
  input  wire logic        prn_online_i, // Printer on-line
  input  wire logic        prn_busy_i,   // Printer busy
  output logic             prn_txd_o,    // Printer serial out
  output logic      [6:0]  prn_data_o,   // Printer parallel data
  output logic             prn_strobe_o, // Parallel data valid
  input  wire logic        kb_valid_i,   // Keyboard character
  input  wire logic [6:0]  kb_data_i,    // Keyboard code
  output logic             kb_lock_o,    // Keyboard lockout
  output logic             cmd_valid_o,  // Received function command
  output logic      [6:0]  cmd_code_o,   // Command code
  output logic             roll_o        // Delete and roll-up request
);
  typedef struct packed {
    mode_t       mode;
    st_t         st;
    dest_t       dest;
    logic [6:0]  x;
    logic [4:0]  y;
    logic [6:0]  sx;
    logic [4:0]  sy;
    logic [6:0]  code;
    logic [1:0]  pend;  // CR/LF still owed: 2 = CR then LF, 1 = LF
    logic        fin;
    logic        nl;
    logic        rollf;
    logic        eotp;
    logic [7:0]  ctrl;
    logic        perr;
    logic        roll;
    logic        mreq;
    logic        mwe;
    logic [7:0]  mwd;
    logic        tv;
    logic [6:0]  pdat;
    logic        pstb;
    logic [3:0]  hold;
    logic        cmdv;
    logic [6:0]  cmdc;
    logic        htxd;
    logic        ctxd;
    logic        ptxd;
    logic        kbl;
    logic        ack;
    logic [31:0] rdat;
    logic [5:0]  s1;
    logic [5:0]  s2;
    logic        cprev;
  } tstate_t;
  tstate_t q, d;
  logic    req, wreq, cmdw, is_eot, wrap, odone;
  dest_t   dsel;
  link_if  lk ();

  baud_gen #(
    .DIV0 (DIV_110),
    .DIV1 (DIV_300),
    .DIV2 (DIV_1200),
    .DIV3 (DIV_2400),
    .DIV4 (DIV_9600)
  ) u_baud (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (q.mode != M_LOCAL),  // [R19]
    .sel_i  (q.ctrl[CF_BAUD +: 3]),  // [R20]
    .tick_o (lk.tick)
  );

  serial_link u_link (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lk    (lk)
  );

  // Link steering; the synchronised pins are the only ones read
  assign lk.tx_valid = q.tv;
  assign lk.tx_data  = q.code;
  assign lk.tx_par   = (q.dest == D_HOST);  // [R2]
  assign lk.tx_ext   = q.ctrl[CF_EXTCLK] && (q.dest == D_CAS);  // [R10]
  assign lk.ext_tick = q.s2[SY_CCK] && !q.cprev;
  assign lk.rxd      = q.ctrl[CF_RXCAS] ? q.s2[SY_CRX] : q.s2[SY_HRX];
  assign lk.rx_chk   = !q.ctrl[CF_RXCAS];  // [R15]

  // Decode helpers
  assign req    = wb_cyc_i && wb_stb_i && !q.ack;
  assign wreq   = req && wb_we_i;
  assign cmdw   = wreq && (wb_adr_i == ADR_CMD) && wb_sel_i[0];
  assign is_eot = (mem_rdata_i[6:5] == EOT_TAG);
  assign wrap   = q.nl || (q.x == X_LAST);
  assign dsel   = (q.mode != M_PRINT) ? D_HOST :
                  q.s2[SY_REC] ? D_CAS :
                  q.ctrl[CF_PAR] ? D_PPAR : D_PSER;  // [R9]
  assign odone  = (q.dest == D_PPAR) ? (q.hold == 4'h0 && !q.s2[SY_BSY])
                                     : (!q.tv && lk.tx_ready);  // [R12]

  always_comb begin
    d = q;
    d.roll = 1'b0;
    d.pstb = 1'b0;
    d.cmdv = 1'b0;
    d.s1 = {prn_online_i, prn_busy_i, cas_rec_i, cas_clk_i, cas_rxd_i, host_rxd_i};
    d.s2 = q.s1;
    d.cprev = q.s2[SY_CCK];
    if (q.tv && lk.tx_ready) begin
      d.tv = 1'b0;
    end
    // Idle lines held at mark so an unused port never sees a frame
    d.htxd = (q.dest == D_HOST) ? lk.txd : 1'b1;
    d.ctxd = (q.dest == D_CAS) ? lk.txd : 1'b1;  // [R9]
    d.ptxd = (q.dest == D_PSER) ? lk.txd : 1'b1;
    d.kbl = (q.mode == M_XMIT) || (q.mode == M_PRINT);  // [R21]

    // Register writes and registered read data
    d.ack = req;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CTRL:  d.rdat = {24'h0, q.ctrl};
        ADR_START: d.rdat = {19'h0, q.sy, 1'b0, q.sx};
        ADR_STAT:  d.rdat = {11'h0, q.y, 1'b0, q.x, 3'h0, q.s2[SY_BSY],
                             q.st != S_IDLE, q.perr, q.mode};
        default:   d.rdat = 32'h0;
      endcase
    end
    if (wreq && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
      d.ctrl = wb_dat_i[7:0];
    end
    if (wreq && wb_adr_i == ADR_START) begin
      if (wb_sel_i[0]) begin
        d.sx = wb_dat_i[6:0];
      end
      if (wb_sel_i[1]) begin
        d.sy = wb_dat_i[12:8];
      end
    end
    // Clear first so a parity failure in the same cycle survives
    if (wreq && wb_adr_i == ADR_STAT && wb_sel_i[0] && wb_dat_i[SB_PERR]) begin
      d.perr = 1'b0;
    end

    unique case (q.st)
      S_IDLE: begin
        if (cmdw && (q.mode == M_RECV || q.mode == M_LOCAL)) begin  // [R21]
          d.fin = 1'b0;
          d.nl = 1'b0;
          d.rollf = 1'b0;
          d.eotp = 1'b0;
          d.pend = 2'h0;
          d.x = q.sx;
          d.y = q.sy;
          if (wb_dat_i[CB_XMIT]) begin
            d.mode = M_XMIT;
            d.st = S_RD;
          end else if (wb_dat_i[CB_PRINT]) begin
            d.mode = M_PRINT;
            d.st = S_RD;
          end else if (wb_dat_i[CB_RECV]) begin
            d.mode = M_RECV;
          end else if (wb_dat_i[CB_LOCAL]) begin
            d.mode = M_LOCAL;  // [R22]
          end
        end else if (q.mode == M_RECV && lk.rx_valid) begin
          if (lk.rx_perr) begin
            d.perr = 1'b1;  // [R23]
          end else if (lk.rx_data >= DISP_LO && lk.rx_data <= DISP_HI) begin
            d.mreq = 1'b1;
            d.mwe = 1'b1;
            d.mwd = {1'b1, lk.rx_data};  // [R16]
            d.st = S_WR;
          end else begin
            d.cmdv = 1'b1;
            d.cmdc = lk.rx_data;  // [R16]
          end
        end else if (q.mode == M_RECV && q.ctrl[CF_DUPLEX] && kb_valid_i) begin
          d.code = kb_data_i;  // [R18]
          d.pend = 2'h0;
          d.st = S_OUT;
        end
      end
      S_RD: begin
        d.mreq = 1'b1;
        d.mwe = 1'b0;
        d.st = S_RDW;
      end
      S_RDW: begin
        if (mem_ack_i) begin
          d.mreq = 1'b0;
          d.nl = 1'b0;
          d.st = S_OUT;
          if (q.mode == M_XMIT) begin
            if (is_eot) begin
              d.code = q.ctrl[CF_EOMCR] ? CH_CR : CH_EOT;  // [R4]
              d.pend = {1'b0, q.ctrl[CF_EOMCR] && q.s2[SY_ONL]};  // [R3]
              d.fin = 1'b1;
              d.rollf = (q.y == Y_LAST);  // [R5]
            end else if (mem_rdata_i[7]) begin
              d.code = mem_rdata_i[6:0];  // [R1]
              d.pend = {1'b0, q.s2[SY_ONL] && mem_rdata_i[6:0] == CH_CR};  // [R3]
            end else begin
              d.st = S_ADV;  // [R1]
            end
          end else if (is_eot) begin
            d.code = CH_CR;  // [R13]
            d.pend = 2'h1;
            d.nl = 1'b1;
            d.fin = q.eotp;  // [R14]
            d.eotp = 1'b1;
          end else begin
            d.code = mem_rdata_i[6:0];  // [R7]
            d.pend = (q.x == X_LAST) ? 2'h2 : 2'h0;  // [R8]
            d.eotp = 1'b0;
          end
        end
      end
      S_OUT: begin
        d.dest = dsel;
        d.st = S_OWT;
        if (dsel == D_PPAR) begin
          d.pdat = q.code;  // [R11]
          d.pstb = 1'b1;
          d.hold = PRN_HOLD;
        end else begin
          d.tv = 1'b1;
        end
      end
      S_OWT: begin
        if (q.hold != 4'h0) begin
          d.hold = q.hold - 4'h1;
        end
        if (odone) begin
          if (q.pend != 2'h0) begin
            d.code = (q.pend == 2'h2) ? CH_CR : CH_LF;  // [R8]
            d.pend = q.pend - 2'h1;
            d.st = S_OUT;
          end else if (q.mode == M_RECV) begin
            d.st = S_IDLE;
          end else begin
            d.st = S_ADV;
          end
        end
      end
      S_ADV: begin
        d.st = S_RD;
        d.nl = 1'b0;
        if (wrap) begin
          d.x = 7'h0;  // [R13]
          if (q.y != Y_LAST) begin
            d.y = q.y + 5'h1;
          end
        end else begin
          d.x = q.x + 7'h1;
        end
        // End of message or end of screen returns to receive
        if (q.fin || (wrap && q.y == Y_LAST)) begin
          d.mode = M_RECV;  // [R4] [R14]
          d.st = S_IDLE;
        end
        if (q.fin && q.rollf) begin
          d.roll = 1'b1;  // [R5]
          d.x = 7'h0;
          d.y = Y_LAST;
        end
      end
      S_WR: begin
        if (mem_ack_i) begin
          d.mreq = 1'b0;
          d.mwe = 1'b0;
          d.st = S_IDLE;
          if (q.x == X_LAST) begin
            d.x = 7'h0;
            if (q.y == Y_LAST) begin
              d.roll = 1'b1;  // [R17]
            end else begin
              d.y = q.y + 5'h1;
            end
          end else begin
            d.x = q.x + 7'h1;
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.htxd <= 1'b1;
      q.ctxd <= 1'b1;
      q.ptxd <= 1'b1;
      q.s1 <= SY_RST;
      q.s2 <= SY_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o     = q.rdat;
  assign wb_ack_o     = q.ack;
  assign mem_req_o    = q.mreq;
  assign mem_we_o     = q.mwe;
  assign mem_x_o      = q.x;
  assign mem_y_o      = q.y;
  assign mem_wdata_o  = q.mwd;
  assign host_txd_o   = q.htxd;
  assign cas_txd_o    = q.ctxd;
  assign prn_txd_o    = q.ptxd;
  assign prn_data_o   = q.pdat;
  assign prn_strobe_o = q.pstb;
  assign kb_lock_o    = q.kbl;
  assign cmd_valid_o  = q.cmdv;
  assign cmd_code_o   = q.cmdc;
  assign roll_o       = q.roll;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_lock;
    (q.mode == M_XMIT || q.mode == M_PRINT) |=> kb_lock_o;
  endproperty
  a_lock: assert property (p_lock) else $error("keyboard not locked"); // [R21]

  property p_entry;
    (q.mode == M_XMIT && $past(q.mode) != M_XMIT) |-> $past(q.mode) != M_PRINT;
  endproperty
  a_entry: assert property (p_entry) else $error("bad transmit entry"); // [R21]

  property p_skip_bg;
    (q.st == S_RDW && mem_ack_i && q.mode == M_XMIT && !is_eot && !mem_rdata_i[7]
      && !(q.x == X_LAST && q.y == Y_LAST)) |=> q.st == S_ADV ##1 q.st == S_RD;
  endproperty
  a_skip_bg: assert property (p_skip_bg) else $error("background sent"); // [R1]

  property p_busy;
    (q.st == S_OWT && q.dest == D_PPAR && q.s2[SY_BSY]) |=> q.st == S_OWT && !prn_strobe_o;
  endproperty
  a_busy: assert property (p_busy) else $error("printer busy ignored"); // [R12]

  property p_cas;
    !cas_txd_o |-> $past(q.dest) == D_CAS;
  endproperty
  a_cas: assert property (p_cas) else $error("cassette driven wrongly"); // [R9]

  property p_roll;
    (q.st == S_WR && mem_ack_i && q.x == X_LAST && q.y == Y_LAST)
      |=> roll_o && q.x == 7'h0 && q.y == Y_LAST;
  endproperty
  a_roll: assert property (p_roll) else $error("roll-up missed"); // [R17]

  property p_lf;
    (q.st == S_RDW && mem_ack_i && q.mode == M_XMIT && !is_eot && mem_rdata_i[7]
      && mem_rdata_i[6:0] == CH_CR && q.s2[SY_ONL]) |=> q.pend == 2'h1;
  endproperty
  a_lf: assert property (p_lf) else $error("no LF after CR"); // [R3]

  property p_perr;
    (q.st == S_IDLE && q.mode == M_RECV && !cmdw && lk.rx_valid && lk.rx_perr)
      |=> q.perr && q.st == S_IDLE && $stable(q.x);
  endproperty
  a_perr: assert property (p_perr) else $error("parity flag lost"); // [R23]

  property p_two_eot;
    (q.st == S_RDW && mem_ack_i && q.mode == M_PRINT && is_eot && q.eotp)
      |=> q.fin && q.pend == 2'h1 && q.code == CH_CR;
  endproperty
  a_two_eot: assert property (p_two_eot) else $error("double EOT missed"); // [R14]

  property p_local;
    (q.mode == M_LOCAL && $past(q.mode) == M_LOCAL) |-> q.st == S_IDLE && !cmd_valid_o;
  endproperty
  a_local: assert property (p_local) else $error("activity in local"); // [R19]
endmodule : terminal_io_mode_processor

// ### far_side_model.sv
module far_side_model (
  input  wire logic       clk_i,   // Clock
  input  wire logic       rst_i,   // Reset
  input  wire logic       req_i,   // Memory request
  input  wire logic [6:0] x_i,     // Column
  input  wire logic [4:0] y_i,     // Line
  input  wire logic       stb_i,   // Printer strobe
  output logic      [7:0] rdata_o, // Read word
  output logic            ack_o,   // Memory done
  output logic            busy_o,  // Printer busy
  output logic            onl_o,   // Printer on-line
  input  wire logic       txd_i,   // Terminal to host line
  output logic            hv_o,    // Host got a character
  output logic      [7:0] hd_o     // Parity and code seen
);
  logic [4:0] cnt_q;
  // Memory answers a cycle on; stale data inverted again on every idle cycle
  always_ff @(posedge clk_i) begin
    ack_o   <= ~rst_i & req_i & ~ack_o;
    rdata_o <= ~(req_i & ~ack_o) ? ~rdata_o :
               (y_i == 5'h00 && x_i == 7'h46) ? 8'hC1 :
               (y_i == 5'h00 && x_i == 7'h47) ? 8'h42 : 8'h60;
    cnt_q   <= rst_i ? 5'h00 : stb_i ? 5'h14 : cnt_q - {4'h0, busy_o};
  end
  // Printer stays busy 20 cycles per character
  assign busy_o = (cnt_q != 5'h00);
  assign onl_o  = 1'b1;
  // Host: deserialise terminal frames mid-bit, 64 clocks a bit
  logic [3:0] hn_q;
  logic [6:0] hct_q;
  logic [8:0] hsh_q;
  always_ff @(posedge clk_i) begin
    hv_o  <= 1'b0;
    hct_q <= hct_q - 7'h01;
    if (rst_i || hn_q == 4'h0) begin
      hn_q  <= {3'h0, ~rst_i & ~txd_i};
      hct_q <= 7'h5E;
    end else if (hct_q == 7'h00) begin
      hn_q  <= (hn_q == 4'h9) ? 4'h0 : hn_q + 4'h1;
      hct_q <= 7'h3F;
      hsh_q <= {txd_i, hsh_q[8:1]};
      hv_o  <= (hn_q == 4'h9);
    end
  end
  assign hd_o = hsh_q[7:0];
endmodule : far_side_model

// ### terminal_io_mode_processor_bench.sv
module terminal_io_mode_processor_bench import ioproc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, hrx = 1'b1, kbv = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic        ack, mreq, mwe, mack, stb, busy, onl, lock, cv, htx, ctx, ptx, roll, hv;
  logic [6:0]  x, pd, cc, code, kbd = 7'h00;
  logic [4:0]  y;
  logic [7:0]  wd, rdat, e, v, hd;
  logic [7:0]  expq[$];
  int          miscompares = 0, check_count = 0, seed = 32'h5697;
  initial forever #2.5 clk_i = ~clk_i;
  terminal_io_mode_processor #(.DIV_110(8), .DIV_300(7), .DIV_1200(6), .DIV_2400(5),
    .DIV_9600(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .mem_req_o(mreq), .mem_we_o(mwe), .mem_x_o(x), .mem_y_o(y), .mem_wdata_o(wd),
    .mem_rdata_i(rdat), .mem_ack_i(mack), .host_rxd_i(hrx), .host_txd_o(htx),
    .cas_rxd_i(1'b1), .cas_txd_o(ctx), .cas_clk_i(1'b0), .cas_rec_i(1'b0),
    .prn_online_i(onl), .prn_busy_i(busy), .prn_txd_o(ptx), .prn_data_o(pd),
    .prn_strobe_o(stb), .kb_valid_i(kbv), .kb_data_i(kbd), .kb_lock_o(lock),
    .cmd_valid_o(cv), .cmd_code_o(cc), .roll_o(roll));
  far_side_model FAR (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .x_i(x), .y_i(y),
    .stb_i(stb), .rdata_o(rdat), .ack_o(mack), .busy_o(busy), .onl_o(onl), .txd_i(htx),
    .hv_o(hv), .hd_o(hd));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; we <= w; adr <= a; dat <= d;
    sel <= (a == ADR_START) ? 4'h3 : 4'h1;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      miscompares++;
      final_report();
    end
    rd = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Host frame, even parity; 64 clocks a bit
  task automatic send(input logic [6:0] c, input logic bad);
    logic [9:0] f;
    f = {1'b1, ^c ^ bad, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hrx <= f[i];
      repeat (64) @(posedge clk_i);
    end
  endtask : send
  task automatic drain();
    int n;
    n = 0;
    while (expq.size() != 0 && n++ < 5000) @(posedge clk_i);
    if (n >= 5000) begin
      miscompares++;
      final_report();
    end
    repeat (40) @(posedge clk_i);
  endtask : drain
  // Each printer, host or command char, memory write and roll takes the oldest note
  always @(posedge clk_i)
    if (stb | cv | hv | roll | (mreq & mwe & mack)) begin
      e = (expq.size() != 0) ? expq.pop_front() : 8'hFF;
      v = stb ? {1'b0, pd} : cv ? {1'b0, cc} : hv ? hd : roll ? {3'h0, y} : wd;
      check("output", {24'h0, v}, {24'h0, e});
    end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, ADR_CTRL, 32'h0);
    check("ctrl", rd, {24'h0, CTRL_RST});
    wb(1'b1, 4'h2, 32'hFF);
    wb(1'b0, ADR_STAT, 32'h0);
    check("status", rd, 32'h0);
    check("lock", lock, 1'b0);
    wb(1'b1, ADR_CTRL, 32'h24);
    wb(1'b1, ADR_START, 32'h46);
    expq = '{8'h41, 8'h42, 8'h0D, 8'h0A, 8'h0D, 8'h0A};
    wb(1'b1, ADR_CMD, 32'h8);
    @(posedge clk_i);
    check("lock", lock, 1'b1);
    drain();
    wb(1'b0, ADR_STAT, 32'h0);
    check("status", rd & 32'h1F7F03, 32'h20001);
    expq = '{8'h41, 8'h84};
    wb(1'b1, ADR_CMD, 32'h4);
    drain();
    expq.push_back(8'h0A);
    send(7'h0A, 1'b0);
    wb(1'b1, ADR_START, 32'h1A49);
    wb(1'b1, ADR_CMD, 32'h1);
    code = 7'h20 + 7'($random(seed) & 32'h3F);
    expq.push_back({1'b1, code});
    expq.push_back(8'h1A);
    send(code, 1'b0);
    expq.push_back(8'h07);
    send(7'h07, 1'b0);
    send(7'h41, 1'b1);
    wb(1'b1, ADR_CTRL, 32'hA4);
    expq.push_back({^code, code});
    kbd <= code;
    kbv <= 1'b1;
    @(posedge clk_i);
    kbv <= 1'b0;
    drain();
    wb(1'b0, ADR_STAT, 32'h0);
    check("parity", rd[2], 1'b1);
    check("cursor", rd & 32'h1F7F00, 32'h1A0000);
    check("idle lines", {ctx, ptx}, 2'b11);
    final_report();
  end
endmodule : terminal_io_mode_processor_bench
